// ---- rtl/lcm_clock_mode_select.sv ----
// clock-mode selection for one line interface channel with its register slave
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
module lcm_clock_mode_select
	import lcm_pkg::*;
#(
	parameter int LOSS_CYCLES = REF_LOSS_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// clock and reference pins, asynchronous to mclk
	input  wire logic        extTxFramerClock,
	input  wire logic        extRxFramerClock,
	input  wire logic        recoveredLineClock,
	input  wire logic        rxOscClock,
	input  wire logic        syncRefClock,
	input  wire logic        gappedRxClockIn,
	input  wire logic        rxOscFramePulse,
	input  wire logic        rxDataFramePulse,
	input  wire logic        lossOfSignal,
	input  wire logic        txOscRefClock,
	// oscillator controls
	output logic             txOscUseProgrammed,
	output logic             txOscFixedSlow,
	output logic      [3:0]  txOscCorner,
	output logic      [4:0]  txOscAtten,
	output logic             txOscCenter,
	output logic             rxOscUseProgrammed,
	output logic             rxOscFixedSlow,
	output logic      [3:0]  rxOscCorner,
	output logic      [4:0]  rxOscAtten,
	output logic             rxOscCenter,
	output logic             rxOscHold,
	// framer side
	output logic             rxWorkClock,
	output logic             txWorkClock,
	output logic             rxFramePulse,
	output logic             rxMfpOut,
	output logic             rxMfpOe
);

	// register and bus state
	logic [7:0]  clkMode_q, clkMode_d;
	logic [20:0] corner_q, corner_d;
	logic [11:0] aux_q, aux_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wait_q, wait_d;
	// pin synchronisers and edge history
	logic [IN_W-1:0] meta_q, sync_q, last_q;
	// reference activity watchdogs
	logic [LOSS_CNT_W-1:0] syncCnt_q, syncCnt_d, gapCnt_q, gapCnt_d, txRefCnt_q, txRefCnt_d;
	// registered outputs, one flop per control so every output leaves a flip-flop
	logic        txUseProg_q, txUseProg_d;
	logic        txFixedSlow_q, txFixedSlow_d;
	logic [3:0]  txCorner_q, txCorner_d;
	logic [4:0]  txAtten_q, txAtten_d;
	logic        txCenter_q, txCenter_d;
	logic        rxUseProg_q, rxUseProg_d;
	logic        rxFixedSlow_q, rxFixedSlow_d;
	logic [3:0]  rxCorner_q, rxCorner_d;
	logic [4:0]  rxAtten_q, rxAtten_d;
	logic        rxCenter_q, rxCenter_d;
	logic        hold_q, hold_d;
	logic        rxWork_q, rxWork_d;
	logic        txWork_q, txWork_d;
	logic        framePulse_q, framePulse_d;
	logic        mfpOe_q, mfpOe_d;
	logic        mfpOut_q, mfpOut_d;

	// a reference counts as missing once its watchdog has saturated
	function automatic logic [LOSS_CNT_W-1:0] watchdog(input logic [LOSS_CNT_W-1:0] cnt, input logic edgeSeen);
		if (edgeSeen)
			return '0;
		else if (cnt == LOSS_CNT_W'(LOSS_CYCLES))
			return cnt;
		else
			return cnt + LOSS_CNT_W'(1);
	endfunction

	logic syncMissing, gapMissing, txRefMissing;
	logic [IN_W-1:0] rise;
	assign rise         = sync_q & ~last_q;
	assign syncMissing  = (syncCnt_q == LOSS_CNT_W'(LOSS_CYCLES));
	assign gapMissing   = (gapCnt_q == LOSS_CNT_W'(LOSS_CYCLES));
	assign txRefMissing = (txRefCnt_q == LOSS_CNT_W'(LOSS_CYCLES));

	// bus: one wait cycle, access commits on the edge where waitrequest is low
	always_comb begin
		logic req;
		logic [3:0] a;
		req       = avs_read | avs_write;
		a         = avs_address;
		clkMode_d = clkMode_q;
		corner_d  = corner_q;
		aux_d     = aux_q;
		rdata_d   = rdata_q;
		wait_d    = 1'b1;
		if (req && wait_q) begin
			wait_d  = 1'b0;
			// read data is prepared now so it stands at the completing edge
			rdata_d = 32'h00000000;
			case (a)
				REG_CLK_MODE: rdata_d = {24'h000000, clkMode_q};
				REG_CORNER:   rdata_d = {11'h000, corner_q};
				REG_AUX_CFG:  rdata_d = {20'h00000, aux_q};
				REG_STATUS:   rdata_d = {26'h0000000, rxCenter_q, txCenter_q, hold_q, txRefMissing, gapMissing,
					syncMissing};
				default:      rdata_d = 32'h00000000;
			endcase
		end
		if (avs_write && !wait_q) begin
			case (a)
				REG_CLK_MODE: clkMode_d = avs_writedata[7:0] & CLK_MODE_WMASK;
				REG_CORNER:   corner_d = {avs_writedata[20:16], 3'h0, avs_writedata[12:0]};
				REG_AUX_CFG:  aux_d = avs_writedata[11:0];
				default:      ;
			endcase
		end
	end

	// watchdogs restart on every rising edge of the watched reference
	always_comb begin
		syncCnt_d  = watchdog(syncCnt_q, rise[IN_SYNC_REF]);
		gapCnt_d   = watchdog(gapCnt_q, rise[IN_GAPPED_CLK]);
		txRefCnt_d = watchdog(txRefCnt_q, rise[IN_TX_REF]);
	end

	// oscillator controls; programmed fields reach the oscillators only while adjustment is on
	always_comb begin
		logic txAdj, rxAdj, master, gapped, centerDis, centerR;
		txAdj         = clkMode_q[TX_OSC_ADJUST_EN_BIT];
		rxAdj         = clkMode_q[RX_OSC_ADJUST_EN_BIT];
		master        = aux_q[MASTER_MODE_BIT];
		gapped        = aux_q[GAPPED_MODE_BIT];
		centerDis     = clkMode_q[RX_OSC_CENTER_DIS_BIT];
		centerR       = 1'b0;
		txUseProg_d   = txAdj;
		// fixed select only matters while adjustment is off
		txFixedSlow_d = !txAdj && aux_q[TX_FIXED_CORNER_BIT];
		txCorner_d    = txAdj ? corner_q[TX_CORNER_LSB +: 4] : 4'h0;
		txAtten_d     = txAdj ? corner_q[TX_ATTEN_LSB +: 5] : 5'h00;
		// with no reference, center on the master-clock derived 2.048 MHz
		txCenter_d    = clkMode_q[TX_OSC_CENTER_EN_BIT] && txRefMissing;
		rxUseProg_d   = rxAdj;
		rxFixedSlow_d = !rxAdj && aux_q[RX_FIXED_CORNER_BIT];
		rxCorner_d    = rxAdj ? corner_q[RX_CORNER_LSB +: 4] : 4'h0;
		rxAtten_d     = rxAdj ? corner_q[RX_ATTEN_LSB +: 5] : 5'h00;
		// master needs only the sync reference; slave centers on a lost line or a stopped gapped clock
		if (master)
			centerR = syncMissing;
		else
			centerR = (sync_q[IN_LOS] && syncMissing) || (gapped && gapMissing);
		rxCenter_d    = !centerDis && centerR;
		// freeze until sync comes back, or in gapped mode until the gapped clock comes back
		hold_d        = centerDis && syncMissing && (gapMissing || !gapped);
	end

	// framer clocks and frame pulse are sampled levels, not true clock muxes
	always_comb begin
		logic rxClk;
		rxClk = sync_q[IN_EXT_RX_CLK];
		// bypass overrides the select bit: the recovered clock always wins there
		if (aux_q[RX_BYPASS_BIT])
			rxClk = sync_q[IN_REC_CLK];
		else if (clkMode_q[INT_RX_FRAMER_CLK_BIT])
			rxClk = sync_q[IN_RX_OSC_CLK];
		rxWork_d = rxClk;
		txWork_d = clkMode_q[INT_TX_FRAMER_CLK_BIT] ? rxClk : sync_q[IN_EXT_TX_CLK];
		// either setting of the frame pulse bit is accepted
		framePulse_d = sync_q[IN_DATA_FRAME];
		if (clkMode_q[INT_RX_FRAME_PULSE_BIT])
			framePulse_d = sync_q[IN_OSC_FRAME];
		// multifunction port drives the oscillator frame pulse active low when coded for it and the internal frame pulse is selected
		mfpOe_d  = clkMode_q[INT_RX_FRAME_PULSE_BIT] && (aux_q[MFP_CODE_LSB +: 4] == MFP_CODE_FRAME);
		mfpOut_d = mfpOe_d ? !sync_q[IN_OSC_FRAME] : 1'b1;
	end

	// bus registers; waitrequest idles high so nothing completes before a request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			clkMode_q <= CLK_MODE_RESET;
			corner_q  <= CORNER_RESET;
			aux_q     <= AUX_RESET;
			rdata_q   <= 32'h00000000;
			wait_q    <= 1'b1;
		end else begin
			clkMode_q <= clkMode_d;
			corner_q  <= corner_d;
			aux_q     <= aux_d;
			rdata_q   <= rdata_d;
			wait_q    <= wait_d;
		end
	end

	// pin synchronisers; only the second stage feeds logic, the third keeps edge history
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end else begin
			meta_q <= {txOscRefClock, lossOfSignal, rxDataFramePulse, rxOscFramePulse, gappedRxClockIn,
				syncRefClock, rxOscClock, recoveredLineClock, extRxFramerClock, extTxFramerClock};
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// reference watchdog counters
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			syncCnt_q  <= '0;
			gapCnt_q   <= '0;
			txRefCnt_q <= '0;
		end else begin
			syncCnt_q  <= syncCnt_d;
			gapCnt_q   <= gapCnt_d;
			txRefCnt_q <= txRefCnt_d;
		end
	end

	// oscillator control registers, all clear at reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txUseProg_q   <= 1'b0;
			txFixedSlow_q <= 1'b0;
			txCorner_q    <= 4'h0;
			txAtten_q     <= 5'h00;
			txCenter_q    <= 1'b0;
			rxUseProg_q   <= 1'b0;
			rxFixedSlow_q <= 1'b0;
			rxCorner_q    <= 4'h0;
			rxAtten_q     <= 5'h00;
			rxCenter_q    <= 1'b0;
			hold_q        <= 1'b0;
		end else begin
			txUseProg_q   <= txUseProg_d;
			txFixedSlow_q <= txFixedSlow_d;
			txCorner_q    <= txCorner_d;
			txAtten_q     <= txAtten_d;
			txCenter_q    <= txCenter_d;
			rxUseProg_q   <= rxUseProg_d;
			rxFixedSlow_q <= rxFixedSlow_d;
			rxCorner_q    <= rxCorner_d;
			rxAtten_q     <= rxAtten_d;
			rxCenter_q    <= rxCenter_d;
			hold_q        <= hold_d;
		end
	end

	// framer side registers; the port idles high so a quiet pin never shows a false pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxWork_q     <= 1'b0;
			txWork_q     <= 1'b0;
			framePulse_q <= 1'b0;
			mfpOe_q      <= 1'b0;
			mfpOut_q     <= 1'b1;
		end else begin
			rxWork_q     <= rxWork_d;
			txWork_q     <= txWork_d;
			framePulse_q <= framePulse_d;
			mfpOe_q      <= mfpOe_d;
			mfpOut_q     <= mfpOut_d;
		end
	end

	// outputs straight from flip-flops
	assign avs_readdata       = rdata_q;
	assign avs_waitrequest    = wait_q;
	assign txOscUseProgrammed = txUseProg_q;
	assign txOscFixedSlow     = txFixedSlow_q;
	assign txOscCorner        = txCorner_q;
	assign txOscAtten         = txAtten_q;
	assign txOscCenter        = txCenter_q;
	assign rxOscCenter        = rxCenter_q;
	assign rxOscUseProgrammed = rxUseProg_q;
	assign rxOscFixedSlow     = rxFixedSlow_q;
	assign rxOscCorner        = rxCorner_q;
	assign rxOscAtten         = rxAtten_q;
	assign rxWorkClock        = rxWork_q;
	assign txWorkClock        = txWork_q;
	assign rxFramePulse       = framePulse_q;
	assign rxOscHold          = hold_q;
	assign rxMfpOut           = mfpOut_q;
	assign rxMfpOe            = mfpOe_q;

endmodule

// ---- rtl/lcm_pkg.sv ----
// constants for the line interface clock-mode select block
package lcm_pkg;
	// register byte offsets on the bus
	localparam logic [3:0] REG_CLK_MODE    = 4'h0;
	localparam logic [3:0] REG_CORNER      = 4'h4;
	localparam logic [3:0] REG_AUX_CFG     = 4'h8;
	localparam logic [3:0] REG_STATUS      = 4'hc;
	// clock_mode_second field positions
	localparam int TX_OSC_ADJUST_EN_BIT    = 7;
	localparam int RX_OSC_ADJUST_EN_BIT    = 6;
	localparam int TX_OSC_CENTER_EN_BIT    = 5;
	localparam int RX_OSC_CENTER_DIS_BIT   = 4;
	localparam int INT_RX_FRAME_PULSE_BIT  = 3;
	localparam int INT_RX_FRAMER_CLK_BIT   = 2;
	localparam int INT_TX_FRAMER_CLK_BIT   = 0;
	localparam logic [7:0] CLK_MODE_WMASK  = 8'hfd;
	localparam logic [7:0] CLK_MODE_RESET  = 8'h00;
	// corner register: tx corner 7:4, rx corner 3:0, tx atten 12:8, rx atten 20:16
	localparam int TX_CORNER_LSB           = 4;
	localparam int RX_CORNER_LSB           = 0;
	localparam int TX_ATTEN_LSB            = 8;
	localparam int RX_ATTEN_LSB            = 16;
	localparam logic [20:0] CORNER_RESET   = 21'h000000;
	// aux register bit positions
	localparam int TX_FIXED_CORNER_BIT     = 0;
	localparam int RX_FIXED_CORNER_BIT     = 1;
	localparam int RX_BYPASS_BIT           = 2;
	localparam int MASTER_MODE_BIT         = 3;
	localparam int GAPPED_MODE_BIT         = 4;
	localparam int MFP_CODE_LSB            = 8;
	localparam logic [11:0] AUX_RESET      = 12'h000;
	localparam logic [3:0] MFP_CODE_FRAME  = 4'h1;
	// reference loss detection: no edge for this long means missing
	localparam int MCLK_HZ                 = 40000000;
	localparam int REF_LOSS_NS             = 2000;
	localparam int REF_LOSS_CYC            = (REF_LOSS_NS * (MCLK_HZ / 1000000)) / 1000;
	localparam int LOSS_CNT_W              = 8;
	// synchroniser lane indices
	localparam int IN_EXT_TX_CLK           = 0;
	localparam int IN_EXT_RX_CLK           = 1;
	localparam int IN_REC_CLK              = 2;
	localparam int IN_RX_OSC_CLK           = 3;
	localparam int IN_SYNC_REF             = 4;
	localparam int IN_GAPPED_CLK           = 5;
	localparam int IN_OSC_FRAME            = 6;
	localparam int IN_DATA_FRAME           = 7;
	localparam int IN_LOS                  = 8;
	localparam int IN_TX_REF               = 9;
	localparam int IN_W                    = 10;
endpackage

// ---- testbench/lcm_pin_model.sv ----
// pin source model: framer clocks, references and pulses, each running or parked
`timescale 1ns/100ps
module lcm_pin_model
	import lcm_pkg::*;
(
	input  wire logic [IN_W-1:0] pinRun,
	input  wire logic [IN_W-1:0] pinLevel,
	output logic      [IN_W-1:0] pinOut
);
	logic tick = 1'b0;
	// free toggle unrelated to mclk, fast enough never to look lost
	always #37 tick = ~tick;
	// a parked line shows the level asked for, so stale values cannot pass
	always_comb pinOut = (pinRun & {IN_W{tick}}) | (~pinRun & pinLevel);
endmodule

// ---- testbench/lcm_clock_mode_select_checker.sv ----
// port assertions for the clock-mode select block
`timescale 1ns/100ps
module lcm_clock_mode_select_checker
	import lcm_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       extTxFramerClock,
	input wire logic       txOscUseProgrammed,
	input wire logic [4:0] txOscAtten,
	input wire logic       rxOscCenter,
	input wire logic       rxOscHold,
	input wire logic       rxWorkClock,
	input wire logic       txWorkClock,
	input wire logic       rxMfpOut,
	input wire logic       rxMfpOe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// one wait cycle per access, low for a single cycle
	chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop after request");
	chk_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	chk_tx_fixed: assert property (!txOscUseProgrammed |-> txOscAtten == 5'h00)
		else $error("tx attenuation visible while adjust disabled");
	chk_tx_adjust_cause: assert property ($rose(txOscUseProgrammed) |-> $past(avs_write, 2) || $past(avs_write, 3))
		else $error("tx adjust rose without a register write");
	chk_hold_center: assert property (rxOscHold |-> !rxOscCenter)
		else $error("rx oscillator held and centered at once");
	chk_tx_clk_src: assert property (txWorkClock == $past(extTxFramerClock, 3) || txWorkClock == rxWorkClock
		|| txWorkClock == $past(rxWorkClock))
		else $error("tx working clock from no allowed source");
	chk_mfp_idle: assert property (!rxMfpOe |-> rxMfpOut)
		else $error("multifunction port low while not driving");
	chk_reset_vals: assert property ($fell(rst) |-> avs_waitrequest && rxMfpOut && !rxMfpOe && !txOscUseProgrammed)
		else $error("outputs not at reset values");
endmodule

// ---- testbench/lcm_clock_mode_select_tb.sv ----
// self-checking bench for the clock-mode select block
`timescale 1ns/100ps
module lcm_clock_mode_select_tb
	import lcm_pkg::*;
();
	logic mclk, rst, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, txOscCorner, rxOscCorner;
	logic [31:0] avs_writedata, avs_readdata, q, d;
	logic [4:0] txOscAtten, rxOscAtten;
	logic txOscUseProgrammed, txOscFixedSlow, txOscCenter, rxOscUseProgrammed, rxOscFixedSlow, rxOscCenter;
	logic rxOscHold, rxWorkClock, txWorkClock, rxFramePulse, rxMfpOut, rxMfpOe, rw;
	logic txOscRefClock, lossOfSignal, rxDataFramePulse, rxOscFramePulse, gappedRxClockIn, syncRefClock;
	logic rxOscClock, recoveredLineClock, extRxFramerClock, extTxFramerClock;
	logic [IN_W-1:0] pinRun, pinLevel, pinOut, p;
	int failures = 0;
	int tests_run = 0;
	logic [3:0] resetAddr [4] = '{4'h0, 4'h4, 4'h8, 4'h2};
	assign {txOscRefClock, lossOfSignal, rxDataFramePulse, rxOscFramePulse, gappedRxClockIn, syncRefClock,
		rxOscClock, recoveredLineClock, extRxFramerClock, extTxFramerClock} = pinOut;
	lcm_clock_mode_select #(.LOSS_CYCLES(8)) uut (.*);
	lcm_pin_model pins (.pinRun(pinRun), .pinLevel(pinLevel), .pinOut(pinOut));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// holds the request until waitrequest is sampled low, then releases
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	function automatic logic rxSel(logic [7:0] m, logic byp, logic [IN_W-1:0] v);
		return byp ? v[IN_REC_CLK] : (m[INT_RX_FRAMER_CLK_BIT] ? v[IN_RX_OSC_CLK] : v[IN_EXT_RX_CLK]);
	endfunction
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(32'h8f1c));
		rst <= 1'b1;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_address <= 4'h0;
		avs_writedata <= 32'h0;
		pinRun <= '0;
		pinLevel <= '0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// reset values, unmapped place, reserved bit
		foreach (resetAddr[i]) begin
			bus(1'b0, resetAddr[i], 32'h0);
			chk(q, 32'h0);
		end
		bus(1'b1, REG_CLK_MODE, 32'hffffffff);
		bus(1'b0, REG_CLK_MODE, 32'h0);
		chk(q, {24'h0, CLK_MODE_WMASK});
		$display("test registers done");
		// corner programming with each adjust combination
		for (int i = 0; i < 4; i++) begin
			d = $urandom;
			bus(1'b1, REG_CORNER, d);
			bus(1'b1, REG_AUX_CFG, {30'h0, d[1:0]});
			bus(1'b1, REG_CLK_MODE, {24'h0, i[1], i[0], 6'h0});
			settle(6);
			chk({txOscUseProgrammed, txOscCorner, txOscAtten}, i[1] ? {1'b1, d[7:4], d[12:8]} : 10'h0);
			if (!i[1]) chk(txOscFixedSlow, d[0]);
			chk(rxOscUseProgrammed, i[0]);
			if (i[0]) chk({rxOscCorner, rxOscAtten}, {d[3:0], d[20:16]});
			else chk(rxOscFixedSlow, d[1]);
		end
		$display("test corners done");
		// framer clock sources over random modes and pin levels
		for (int i = 0; i < 24; i++) begin
			p = IN_W'($urandom);
			d = $urandom & 32'h00000f1f;
			pinLevel <= p;
			bus(1'b1, REG_AUX_CFG, d);
			bus(1'b1, REG_CLK_MODE, {24'h0, i[7:0] ^ d[7:0]});
			settle(6);
			rw = rxSel(i[7:0] ^ d[7:0], d[RX_BYPASS_BIT], p);
			chk(rxWorkClock, rw);
			chk(txWorkClock, (i[0] ^ d[0]) ? rw : p[IN_EXT_TX_CLK]);
		end
		$display("test clocks done");
		// frame pulse source and port drive
		for (int i = 0; i < 8; i++) begin
			p = IN_W'($urandom);
			pinLevel <= p;
			bus(1'b1, REG_CLK_MODE, {28'h0, i[0], 3'h0});
			bus(1'b1, REG_AUX_CFG, {20'h0, i[1] ? MFP_CODE_FRAME : 4'h2, 8'h0});
			settle(6);
			rw = i[0] ? p[IN_OSC_FRAME] : p[IN_DATA_FRAME];
			chk(rxFramePulse, rw);
			chk({rxMfpOe, rxMfpOut}, (i[0] && i[1]) ? {1'b1, !rw} : 2'b01);
		end
		$display("test frame pulse done");
		// centering and hold with references parked low, then the sync and tx references running in turn
		pinLevel <= '0;
		bus(1'b1, REG_CLK_MODE, 32'h20);
		bus(1'b1, REG_AUX_CFG, 32'h08);
		settle(24);
		chk({txOscCenter, rxOscCenter, rxOscHold}, 3'b110);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(q, 32'h00000037);
		bus(1'b1, REG_CLK_MODE, 32'h10);
		settle(24);
		chk({txOscCenter, rxOscCenter, rxOscHold}, 3'b001);
		pinRun[IN_SYNC_REF] <= 1'b1;
		settle(24);
		chk(rxOscHold, 1'b0);
		pinRun <= '0;
		pinLevel[IN_LOS] <= 1'b1;
		bus(1'b1, REG_AUX_CFG, 32'h0);
		bus(1'b1, REG_CLK_MODE, 32'h20);
		pinRun[IN_TX_REF] <= 1'b1;
		settle(24);
		chk({txOscCenter, rxOscCenter}, 2'b01);
		$display("test centering done");
		conclude();
	end
endmodule
bind lcm_clock_mode_select lcm_clock_mode_select_checker chk_i (.*);
